// ---- hdl/ghbi_top.sv ----
// Graphics host bus interface: host cycles, decode, wait states, display memory, registers
//
// Summary of operation
// R1: Reset leaves memory and I/O cycles 8-bit
// R2: Separate 16-bit enables for memory and I/O
// R3: 16-bit I/O only at indexed register pairs
// R4: Palette, misc and status ports always 8-bit
// R5: A0 and high byte enable pick width
// R6: I/O cycles complete with no wait states
// R7: Memory cycles stretched until memory access ends
// R8: Strap picks PC or channel bus signals
// R9: PC bus: ROM range drives ROM select
// R10: Channel bus: external video ROM never enabled
// R11: Extended registers disabled after reset
// R12: Software sets two enable groups before writing
// R13: Latches and attribute flip-flop readable back
// R14: Palette range gives DAC read, write strobes
// R15: Whole memory reachable in all three organisations
// R16: Memory cycles sequenced from the memory clock
// R17: Extended writes ignored until both enables set
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`include "ghbi_defines.svh"
module ghbi_top #(
	parameter int MEM_WORDS = `GHBI_MEM_WORDS,
	parameter int MSEQ_WAIT = `GHBI_MSEQ_WAIT
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic bus_sel_strap,
	input wire logic [19:0] host_addr,
	input wire logic host_mem_rd_n,
	input wire logic host_mem_wr_n,
	input wire logic host_io_rd_n,
	input wire logic host_io_wr_n,
	input wire logic byte_high_enable_n,
	input wire ghbi_pkg::ghbi_word_t host_data_in,
	output ghbi_pkg::ghbi_word_t host_data_out,
	output logic host_data_oe_n,
	output logic pc_ready,
	output logic pc_mem16_n,
	output logic pc_io16_n,
	output logic ch_ready,
	output logic ch_ds16_n,
	output logic ch_card_sel_n,
	output logic rom_chip_select_n,
	output logic pal_rd_n,
	output logic pal_wr_n
);
	import ghbi_pkg::*;
	localparam int AW = $clog2(MEM_WORDS);

	if (MEM_WORDS < 2 || MEM_WORDS > `GHBI_MEM_WORDS_MAX ||
		(MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_chk_words
		$error("MEM_WORDS must be a power of two up to the full display memory");
	end
	if (MSEQ_WAIT < 1 || MSEQ_WAIT > `GHBI_MSEQ_WAIT_MAX) begin : g_chk_wait
		$error("MSEQ_WAIT out of range");
	end

	ghbi_mem_if #(.AW(AW)) mif (.clk(mclk));
	ghbi_vmem #(.AW(AW)) u_vmem (.mif(mif));

	ghbi_state_t st_ff, nxt_st;
	logic [3:0] cnt_ff, nxt_cnt;
	logic cmd_ff, bus_ch_ff, strap_done_ff;
	logic [6:0] ctrl_ff;
	logic ext_a_ff, ext_b_ff, attr_ff, drive_ff, cyc16_ff, lane_ff;
	ghbi_byte_t scr_ff, misc_ff;
	ghbi_word_t latch_ff, dout_ff;
	logic [31:0] rdata_ff;
	logic wait_ff, rdy_ff_pc, rdy_ff_ch, mem16_ff, io16_ff, ds16_ff, csel_ff;
	logic rom_chip_select_ff, palrd_ff, palwr_ff;
	logic [17:0] ba;

	// Host command decode
	wire logic mem_rd = !host_mem_rd_n;
	wire logic mem_wr = !host_mem_wr_n;
	wire logic io_rd = !host_io_rd_n;
	wire logic io_wr = !host_io_wr_n;
	wire logic mem_cmd = mem_rd | mem_wr;
	wire logic io_cmd = io_rd | io_wr;
	wire logic any_cmd = mem_cmd | io_cmd;
	wire logic cmd_start = any_cmd & ~cmd_ff;
	wire logic is_idle = (st_ff == GHBI_ST_IDLE);
	wire logic io_wr_go = cmd_start & io_wr & is_idle;
	wire logic io_rd_go = cmd_start & io_rd & is_idle;
	wire logic bus_pc = ~bus_ch_ff;
	wire logic [9:0] port = host_addr[9:0];
	wire logic in_vram = (host_addr[19:17] == `GHBI_VRAM_HI);
	wire logic in_rom = (host_addr[19:15] == `GHBI_ROM_HI);
	wire logic is_pal = (port >= `GHBI_P_PAL_LO) && (port <= `GHBI_P_PAL_HI); // [R14]
	wire logic mono = ~misc_ff[0];
	wire logic [9:0] crt_base = mono ? `GHBI_P_CRTM : `GHBI_P_CRTC;
	wire logic is_stat = io_cmd & (port == (mono ? `GHBI_P_STATM : `GHBI_P_STATC));
	wire logic is_miscw = io_cmd & (port == `GHBI_P_MISCW);
	wire logic is_miscr = io_cmd & (port == `GHBI_P_MISCR);

	// Control fields; all clear after reset so both paths start 8-bit
	wire logic mem16_en = ctrl_ff[`GHBI_CTRL_MEM16]; // [R2]
	wire logic io16_en = ctrl_ff[`GHBI_CTRL_IO16]; // [R2]
	wire ghbi_org_t org = ghbi_org_t'(ctrl_ff[`GHBI_CTRL_ORG]);
	wire logic [1:0] plane = ctrl_ff[`GHBI_CTRL_PLANE];
	wire logic page = ctrl_ff[`GHBI_CTRL_PAGE];
	wire logic ext_on = ext_a_ff & ext_b_ff; // [R11] [R12]

	// Width choice per cycle
	wire logic want16 = ~host_addr[0] & ~byte_high_enable_n; // [R5]
	wire logic mem_cyc16 = mem16_en & want16; // [R5]
	wire ghbi_byte_t byte_in = (host_addr[0] & ~byte_high_enable_n) ?
		host_data_in[15:8] : host_data_in[7:0];

	// Indexed register pairs: sequencer, graphics, CRT, attribute
	logic [9:0] base_w [4];
	logic [3:0] hit_idx, hit_dat;
	ghbi_byte_t idx_ff [4];
	ghbi_byte_t dat_ff [4];
	ghbi_byte_t rd_i [4];
	ghbi_byte_t rd_d [4];
	assign base_w[0] = `GHBI_P_SEQ;
	assign base_w[1] = `GHBI_P_GC;
	assign base_w[2] = crt_base;
	assign base_w[3] = `GHBI_P_ATTR;
	wire logic any_idx = |hit_idx;
	wire logic io_cyc16 = io16_en & want16 & any_idx; // [R3] [R4]

	for (genvar i = 0; i < 4; i++) begin : g_pair
		wire logic is_attr = (i == 3);
		assign hit_idx[i] = io_cmd & (port == base_w[i]);
		assign hit_dat[i] = io_cmd & (port == (base_w[i] + 10'h001));
		// Attribute index and data share one port, steered by the flip-flop
		wire logic idx_we = io_wr_go & hit_idx[i] & (~is_attr | io_cyc16 | ~attr_ff);
		wire logic dat_we = io_wr_go & ((hit_dat[i] & ~is_attr) | (hit_idx[i] & io_cyc16) |
			(hit_idx[i] & is_attr & attr_ff & ~io_cyc16));
		wire ghbi_byte_t dat_in = io_cyc16 ? host_data_in[15:8] : byte_in; // [R3]
		assign rd_i[i] = hit_idx[i] ? idx_ff[i] : 8'h00;
		assign rd_d[i] = hit_dat[i] ? dat_ff[i] : 8'h00;
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				idx_ff[i] <= 8'h00;
				dat_ff[i] <= 8'h00;
			end else begin
				if (idx_we) begin
					idx_ff[i] <= host_data_in[7:0];
				end
				if (dat_we) begin
					dat_ff[i] <= dat_in;
				end
			end
		end
	end

	// Host I/O read data; 8-bit answers repeat on both lanes
	wire ghbi_byte_t idx_rd = rd_i[0] | rd_i[1] | rd_i[2] | rd_i[3];
	wire ghbi_byte_t dat_rd = rd_d[0] | rd_d[1] | rd_d[2] | rd_d[3];
	wire ghbi_byte_t pair_hi = hit_idx[0] ? dat_ff[0] : hit_idx[1] ? dat_ff[1] :
		hit_idx[2] ? dat_ff[2] : dat_ff[3];
	wire ghbi_byte_t io_byte = any_idx ? idx_rd : (|hit_dat) ? dat_rd :
		is_miscr ? misc_ff : `GHBI_STAT_VAL;
	wire ghbi_word_t io_rdata = io_cyc16 ? {pair_hi, idx_rd} : {io_byte, io_byte}; // [R3] [R4]
	wire logic our_port = any_idx | (|hit_dat) | is_stat | is_miscr;

	// Host address to display memory byte address per organisation
	always_comb begin
		unique case (org)
			GHBI_ORG_PLANAR: ba = {plane, host_addr[15:0]}; // [R15]
			GHBI_ORG_CHAIN2: ba = {plane[1], host_addr[0], host_addr[16:1]}; // [R15]
			GHBI_ORG_CHAIN4: ba = {host_addr[1:0], page, host_addr[16:2]}; // [R15]
			default: ba = {plane, host_addr[15:0]};
		endcase
	end

	// Memory request goes out in the cycle the host command is first seen
	wire logic mem_go = cmd_start & mem_cmd & in_vram & is_idle;
	assign mif.req = mem_go;
	assign mif.we = mem_wr;
	assign mif.addr = ba[AW:1];
	assign mif.be = mem_cyc16 ? 2'b11 : (ba[0] ? 2'b10 : 2'b01);
	assign mif.wdata = mem_cyc16 ? host_data_in : {byte_in, byte_in};

	// Sequencer: memory cycles wait, I/O cycles never leave idle
	wire logic mem_done = (st_ff == GHBI_ST_MEM) && (cnt_ff == 4'h0);
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		unique case (st_ff)
			GHBI_ST_IDLE: begin
				if (mem_go) begin
					nxt_st = GHBI_ST_MEM;
					nxt_cnt = 4'(MSEQ_WAIT - 1); // [R16]
				end
			end
			GHBI_ST_MEM: begin
				if (cnt_ff == 4'h0) begin
					nxt_st = GHBI_ST_HOLD;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			GHBI_ST_HOLD: begin
				if (!any_cmd) begin
					nxt_st = GHBI_ST_IDLE;
				end
			end
			default: nxt_st = GHBI_ST_IDLE;
		endcase
	end

	// Ready falls only for memory; an I/O cycle never enters the wait state
	wire logic nxt_ready = (nxt_st != GHBI_ST_MEM); // [R6] [R7]
	wire ghbi_word_t mem_rword = cyc16_ff ? mif.rdata :
		(lane_ff ? {mif.rdata[15:8], mif.rdata[15:8]} : {mif.rdata[7:0], mif.rdata[7:0]});

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= GHBI_ST_IDLE;
			cnt_ff <= 4'h0;
			cmd_ff <= 1'b0;
			cyc16_ff <= 1'b0;
			lane_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			cmd_ff <= any_cmd;
			if (mem_go) begin
				cyc16_ff <= mem_cyc16;
				lane_ff <= ba[0];
			end
		end
	end

	// Strap is caught on the first edge after reset release, then frozen
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strap_done_ff <= 1'b0;
			bus_ch_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_done_ff <= 1'b1;
			bus_ch_ff <= bus_sel_strap; // [R8]
		end
	end

	// Attribute flip-flop, misc output, processor latches, host data
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			attr_ff <= 1'b0;
			misc_ff <= 8'h00;
			latch_ff <= 16'h0000;
			dout_ff <= 16'h0000;
			drive_ff <= 1'b0;
		end else begin
			if (io_rd_go & is_stat) begin
				attr_ff <= 1'b0;
			end else if (io_wr_go & hit_idx[3] & ~io_cyc16) begin
				attr_ff <= ~attr_ff;
			end
			if (io_wr_go & is_miscw) begin
				misc_ff <= byte_in;
			end
			if (mem_done & mem_rd) begin
				latch_ff <= mif.rdata; // [R13]
				dout_ff <= mem_rword;
			end else if (io_rd_go & our_port) begin
				dout_ff <= io_rdata;
			end
			// Set wins over the end-of-command clear
			if ((mem_done & mem_rd) | (io_rd_go & our_port)) begin
				drive_ff <= 1'b1;
			end else if (!any_cmd) begin
				drive_ff <= 1'b0;
			end
		end
	end

	// Bus side control outputs; the unchosen bus is held inactive
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdy_ff_pc <= 1'b1;
			rdy_ff_ch <= 1'b1;
			mem16_ff <= 1'b1;
			io16_ff <= 1'b1;
			ds16_ff <= 1'b1;
			csel_ff <= 1'b1;
			rom_chip_select_ff <= 1'b1;
			palrd_ff <= 1'b1;
			palwr_ff <= 1'b1;
		end else begin
			rdy_ff_pc <= bus_pc ? nxt_ready : 1'b1; // [R8] [R7]
			rdy_ff_ch <= bus_ch_ff ? nxt_ready : 1'b1; // [R8] [R7]
			mem16_ff <= ~(bus_pc & mem_cmd & in_vram & mem16_en); // [R2]
			io16_ff <= ~(bus_pc & io_cmd & io16_en & any_idx); // [R3]
			ds16_ff <= ~(bus_ch_ff & ((mem_cmd & in_vram & mem16_en) |
				(io_cmd & io16_en & any_idx)));
			csel_ff <= ~(bus_ch_ff & ((mem_cmd & in_vram) | our_port | is_miscw));
			// Channel bus firmware carries the video code, so no ROM select there
			rom_chip_select_ff <= ~(bus_pc & mem_rd & in_rom); // [R9] [R10]
			palrd_ff <= ~(io_rd & is_pal); // [R14]
			palwr_ff <= ~(io_wr & is_pal); // [R14]
		end
	end

	// Avalon slave: one wait cycle on every access
	wire logic av_req = avs_read | avs_write;
	wire logic av_wr = avs_write & ~wait_ff;
	wire logic sel_ctrl = (avs_address == `GHBI_OFF_CTRL);
	wire logic sel_exta = (avs_address == `GHBI_OFF_EXTA);
	wire logic sel_extb = (avs_address == `GHBI_OFF_EXTB);
	wire logic sel_scr = (avs_address == `GHBI_OFF_SCR);
	wire logic sel_latch = (avs_address == `GHBI_OFF_LATCH);
	wire logic sel_attr = (avs_address == `GHBI_OFF_ATTR);
	wire logic sel_stat = (avs_address == `GHBI_OFF_STAT);
	wire logic [31:0] ext_rd = sel_scr ? {24'h000000, scr_ff} :
		sel_latch ? {16'h0000, latch_ff} :
		sel_attr ? {31'h00000000, attr_ff} : 32'h00000000;
	wire logic [31:0] av_rmux = sel_ctrl ? {25'h0000000, ctrl_ff} :
		sel_exta ? {31'h00000000, ext_a_ff} :
		sel_extb ? {31'h00000000, ext_b_ff} :
		sel_stat ? {26'h0000000, st_ff, ext_on, bus_ch_ff, attr_ff} :
		(ext_on ? ext_rd : 32'h00000000); // [R11] [R13]

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
			ctrl_ff <= `GHBI_CTRL_RST; // [R1]
			ext_a_ff <= 1'b0; // [R11]
			ext_b_ff <= 1'b0; // [R11]
			scr_ff <= 8'h00;
		end else begin
			wait_ff <= ~(av_req & wait_ff);
			if (avs_read & wait_ff) begin
				rdata_ff <= av_rmux;
			end
			if (av_wr & sel_ctrl) begin
				ctrl_ff <= avs_writedata[6:0];
			end
			if (av_wr & sel_exta) begin
				ext_a_ff <= avs_writedata[`GHBI_EXT_BIT];
			end
			if (av_wr & sel_extb) begin
				ext_b_ff <= avs_writedata[`GHBI_EXT_BIT];
			end
			if (av_wr & sel_scr & ext_on) begin
				scr_ff <= avs_writedata[7:0]; // [R17] [R12]
			end
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign host_data_out = dout_ff;
	assign host_data_oe_n = ~drive_ff;
	assign pc_ready = rdy_ff_pc;
	assign ch_ready = rdy_ff_ch;
	assign pc_mem16_n = mem16_ff;
	assign pc_io16_n = io16_ff;
	assign ch_ds16_n = ds16_ff;
	assign ch_card_sel_n = csel_ff;
	assign rom_chip_select_n = rom_chip_select_ff;
	assign pal_rd_n = palrd_ff;
	assign pal_wr_n = palwr_ff;
endmodule

// ---- hdl/ghbi_defines.svh ----
// Constants for the graphics host bus interface: offsets, fields, ports, counts
`ifndef GHBI_DEFINES_SVH
`define GHBI_DEFINES_SVH
`define GHBI_OFF_CTRL 6'h00
`define GHBI_OFF_EXTA 6'h04
`define GHBI_OFF_EXTB 6'h08
`define GHBI_OFF_SCR 6'h0c
`define GHBI_OFF_LATCH 6'h10
`define GHBI_OFF_ATTR 6'h14
`define GHBI_OFF_STAT 6'h18
`define GHBI_CTRL_RST 7'h00
`define GHBI_CTRL_MEM16 0
`define GHBI_CTRL_IO16 1
`define GHBI_CTRL_ORG 3:2
`define GHBI_CTRL_PLANE 5:4
`define GHBI_CTRL_PAGE 6
`define GHBI_EXT_BIT 0
`define GHBI_VRAM_HI 3'h5
`define GHBI_ROM_HI 5'h18
`define GHBI_P_ATTR 10'h3c0
`define GHBI_P_SEQ 10'h3c4
`define GHBI_P_GC 10'h3ce
`define GHBI_P_CRTM 10'h3b4
`define GHBI_P_CRTC 10'h3d4
`define GHBI_P_STATM 10'h3ba
`define GHBI_P_STATC 10'h3da
`define GHBI_P_MISCW 10'h3c2
`define GHBI_P_MISCR 10'h3cc
`define GHBI_P_PAL_LO 10'h3c6
`define GHBI_P_PAL_HI 10'h3c9
`define GHBI_STAT_VAL 8'h00
`define GHBI_MSEQ_WAIT 2
`define GHBI_MEM_WORDS 131072
`define GHBI_MEM_WORDS_MAX 131072
`define GHBI_MSEQ_WAIT_MAX 15
`endif

// ---- hdl/ghbi_pkg.sv ----
// Types shared by the graphics host bus interface modules
package ghbi_pkg;
	typedef logic [15:0] ghbi_word_t;
	typedef logic [7:0] ghbi_byte_t;
	typedef enum logic [2:0] {
		GHBI_ST_IDLE = 3'b001,
		GHBI_ST_MEM = 3'b010,
		GHBI_ST_HOLD = 3'b100
	} ghbi_state_t;
	typedef enum logic [1:0] {
		GHBI_ORG_PLANAR = 2'h0,
		GHBI_ORG_CHAIN2 = 2'h1,
		GHBI_ORG_CHAIN4 = 2'h2
	} ghbi_org_t;
endpackage

// ---- hdl/ghbi_mem_if.sv ----
// Display memory request and read data between the bus logic and the memory
interface ghbi_mem_if #(parameter int AW = 17) (input logic clk);
	logic req;
	logic we;
	logic [1:0] be;
	logic [AW-1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport ctrl (input clk, output req, output we, output be, output addr, output wdata,
		input rdata);
	modport mem (input clk, input req, input we, input be, input addr, input wdata,
		output rdata);
endinterface

// ---- hdl/ghbi_vmem.sv ----
// Display memory: 16-bit words, byte lane writes, registered read data
module ghbi_vmem #(
	parameter int AW = 17
) (
	ghbi_mem_if.mem mif
);
	import ghbi_pkg::*;
	logic [7:0] lane_mem [2][2**AW];
	ghbi_word_t rdata_ff;

	// One lane per byte so a byte write leaves its neighbour untouched
	for (genvar l = 0; l < 2; l++) begin : g_lane
		always_ff @(posedge mif.clk) begin
			if (mif.req && mif.we && mif.be[l]) begin
				lane_mem[l][mif.addr] <= mif.wdata[l*8 +: 8];
			end
			if (mif.req && !mif.we) begin
				rdata_ff[l*8 +: 8] <= lane_mem[l][mif.addr];
			end
		end
	end

	assign mif.rdata = rdata_ff;
endmodule

// ---- test/ghbi_chk.sv ----
// Checker of host cycle timing and decode at the block ports
`include "ghbi_defines.svh"
module ghbi_chk #(
	parameter int MEM_WORDS = 131072,
	parameter int MSEQ_WAIT = 2
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic bus_sel_strap,
	input wire logic [19:0] host_addr,
	input wire logic host_mem_rd_n,
	input wire logic host_mem_wr_n,
	input wire logic host_io_rd_n,
	input wire logic host_io_wr_n,
	input wire logic pc_ready,
	input wire logic pc_mem16_n,
	input wire logic pc_io16_n,
	input wire logic ch_ready,
	input wire logic rom_chip_select_n,
	input wire logic pal_rd_n,
	input wire logic pal_wr_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic rdy;
	logic pal;
	logic win;
	logic [3:0] low_ff;
	assign rdy = pc_ready & ch_ready;
	assign pal = host_addr[9:0] >= `GHBI_P_PAL_LO && host_addr[9:0] <= `GHBI_P_PAL_HI;
	assign win = host_addr[19:17] == `GHBI_VRAM_HI;
	// Counts wait cycles so a long wait needs no long repetition
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			low_ff <= 4'h0;
		end else begin
			low_ff <= rdy ? 4'h0 : low_ff + 4'h1;
		end
	end
	sequence s_io_start;
		$fell(host_io_rd_n) || $fell(host_io_wr_n);
	endsequence
	sequence s_mem_start;
		($fell(host_mem_rd_n) || $fell(host_mem_wr_n)) && win;
	endsequence
	a_io_no_wait: assert property (s_io_start |-> rdy [*3])
		else $error("io cycle stretched");
	a_mem_stretch: assert property (s_mem_start |=> !rdy)
		else $error("memory cycle not stretched");
	a_wait_len: assert property ($rose(rdy) |-> low_ff == MSEQ_WAIT)
		else $error("memory wait length wrong");
	a_wait_bound: assert property (!rdy |-> low_ff < MSEQ_WAIT)
		else $error("memory wait too long");
	a_rom_select: assert property ($fell(host_mem_rd_n)
		&& host_addr[19:15] == `GHBI_ROM_HI && !bus_sel_strap |=> !rom_chip_select_n)
		else $error("rom select missing");
	a_rom_cause: assert property (!rom_chip_select_n |->
		$past(!host_mem_rd_n && host_addr[19:15] == `GHBI_ROM_HI))
		else $error("rom select without cause");
	a_rom_chan_off: assert property (bus_sel_strap |-> rom_chip_select_n)
		else $error("rom selected on channel bus");
	a_pal_wr: assert property ($fell(host_io_wr_n) && pal |=> !pal_wr_n)
		else $error("palette write strobe missing");
	a_pal_rd_cause: assert property (!pal_rd_n |-> $past(!host_io_rd_n && pal))
		else $error("palette read strobe without cause");
	a_io16_cause: assert property (!pc_io16_n |->
		$past(!(host_io_rd_n && host_io_wr_n) && !host_addr[0] && !pal))
		else $error("16-bit io where not allowed");
	a_mem16_cause: assert property (!pc_mem16_n |->
		$past(!(host_mem_rd_n && host_mem_wr_n) && win))
		else $error("16-bit memory without cycle");
endmodule
bind ghbi_top ghbi_chk #(.MEM_WORDS(MEM_WORDS), .MSEQ_WAIT(MSEQ_WAIT)) u_chk (
	.mclk(mclk), .resetn(resetn), .bus_sel_strap(bus_sel_strap), .host_addr(host_addr),
	.host_mem_rd_n(host_mem_rd_n), .host_mem_wr_n(host_mem_wr_n),
	.host_io_rd_n(host_io_rd_n), .host_io_wr_n(host_io_wr_n), .pc_ready(pc_ready),
	.pc_mem16_n(pc_mem16_n), .pc_io16_n(pc_io16_n), .ch_ready(ch_ready),
	.rom_chip_select_n(rom_chip_select_n), .pal_rd_n(pal_rd_n), .pal_wr_n(pal_wr_n));

// ---- test/ghbi_host.sv ----
// Host processor model: runs memory and io command cycles
module ghbi_host (
	input wire logic mclk,
	input wire logic rdy,
	input wire ghbi_pkg::ghbi_word_t data_out,
	output logic [19:0] addr,
	output logic [3:0] cmd_n,
	output logic bhe_n,
	output ghbi_pkg::ghbi_word_t data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import ghbi_pkg::*;
	initial begin
		addr = 20'h00000;
		cmd_n = 4'hf;
		bhe_n = 1'b1;
		data_in = 16'h0000;
	end
	// Kind: 0 mem read, 1 mem write, 2 io read, 3 io write
	task automatic run(input logic [1:0] k, input logic [19:0] a, input ghbi_word_t d,
		input logic b, output ghbi_word_t rd, output int waits);
		waits = 0;
		rd = 16'h0000;
		@(posedge mclk);
		addr <= a;
		bhe_n <= b;
		data_in <= d;
		cmd_n <= ~(4'h1 << k);
		for (int i = 0; i < 24; i++) begin
			@(posedge mclk);
			rd = data_out;
			if (!rdy) begin
				waits++;
			end else if (waits > 0 || i > 0) begin
				break;
			end
		end
		cmd_n <= 4'hf;
		// Released lines flip so stale values never look valid
		addr <= ~a;
		data_in <= ~d;
		bhe_n <= ~b;
		repeat (2) @(posedge mclk);
	endtask
endmodule

// ---- test/tb_graphics_host_bus_interface.sv ----
// Self-checking bench for the graphics host bus interface
`include "ghbi_defines.svh"
module tb_graphics_host_bus_interface;
	timeunit 1ns;
	timeprecision 1ns;
	import ghbi_pkg::*;
	localparam int WAITS = 3;
	localparam int B_OE = 7, B_M16 = 6, B_I16 = 5, B_DS = 4, B_CS = 3, B_ROM = 2, B_PRD = 1;
	localparam int B_PWR = 0;
	localparam logic [1:0] MRD = 2'd0, MWR = 2'd1, IRD = 2'd2, IWR = 2'd3;
	logic mclk, resetn, strap, avs_read, avs_write, avs_waitrequest, bhe_n, clr, oe_n;
	logic pc_ready, ch_ready, pc_mem16_n, pc_io16_n, ch_ds16_n, ch_card_sel_n;
	logic rom_n, pal_rd_n, pal_wr_n;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [19:0] haddr;
	logic [3:0] cmd_n;
	logic [7:0] lows;
	ghbi_word_t hdin, hdout, hrd;
	int hw, err_count, samples_checked, cyc;
	ghbi_top #(.MEM_WORDS(1024), .MSEQ_WAIT(WAITS)) i_dut (.mclk(mclk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .bus_sel_strap(strap), .host_addr(haddr),
		.host_mem_rd_n(cmd_n[0]), .host_mem_wr_n(cmd_n[1]), .host_io_rd_n(cmd_n[2]),
		.host_io_wr_n(cmd_n[3]), .byte_high_enable_n(bhe_n), .host_data_in(hdin),
		.host_data_out(hdout), .host_data_oe_n(oe_n), .pc_ready(pc_ready),
		.pc_mem16_n(pc_mem16_n), .pc_io16_n(pc_io16_n), .ch_ready(ch_ready),
		.ch_ds16_n(ch_ds16_n), .ch_card_sel_n(ch_card_sel_n), .rom_chip_select_n(rom_n),
		.pal_rd_n(pal_rd_n), .pal_wr_n(pal_wr_n));
	ghbi_host u_host (.mclk(mclk), .rdy(pc_ready & ch_ready), .data_out(hdout),
		.addr(haddr), .cmd_n(cmd_n), .bhe_n(bhe_n), .data_in(hdin));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Remembers every select that went low during one host cycle
	always @(posedge mclk) begin
		lows <= clr ? 8'h00 : lows | ~{oe_n, pc_mem16_n, pc_io16_n, ch_ds16_n, ch_card_sel_n,
			rom_n, pal_rd_n, pal_wr_n};
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n == 50) err_count++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		av(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		av(1'b0, a, 32'h0, q);
		check(q & m, e);
	endtask
	task automatic hc(input logic [1:0] k, input logic [19:0] a, input ghbi_word_t d,
		input logic b);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		u_host.run(k, a, d, b, hrd, hw);
	endtask
	task automatic do_reset(input logic s);
		resetn <= 1'b0;
		strap <= s;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask
	task automatic t_reset();
		rd(`GHBI_OFF_CTRL, 32'hffffffff, 32'h0);
		rd(`GHBI_OFF_STAT, 32'h4, 32'h0);
		hc(IWR, 20'h003c4, 16'h0000, 1'b0);
		check(lows[B_I16], 0);
		check(hw, 0);
		hc(MWR, 20'ha0000, 16'h1234, 1'b0);
		check(lows[B_M16], 0);
		check(hw, WAITS);
	endtask
	task automatic t_ext();
		wr(`GHBI_OFF_SCR, 32'h5a);
		rd(`GHBI_OFF_SCR, 32'hffffffff, 32'h0);
		wr(`GHBI_OFF_EXTA, 32'h1);
		wr(`GHBI_OFF_SCR, 32'h5a);
		wr(`GHBI_OFF_EXTB, 32'h1);
		// Both enables now set: earlier writes must not have landed
		rd(`GHBI_OFF_SCR, 32'hffffffff, 32'h0);
		wr(`GHBI_OFF_SCR, 32'ha5);
		rd(`GHBI_OFF_SCR, 32'hffffffff, 32'ha5);
		wr(`GHBI_OFF_EXTA, 32'h0);
		wr(`GHBI_OFF_SCR, 32'h3c);
		wr(`GHBI_OFF_EXTA, 32'h1);
		rd(`GHBI_OFF_SCR, 32'hffffffff, 32'ha5);
		rd(6'h3c, 32'hffffffff, 32'h0);
		hc(IWR, 20'h003c0, 16'h0000, 1'b1);
		rd(`GHBI_OFF_ATTR, 32'h1, 32'h1);
		hc(IRD, 20'h003ba, 16'h0000, 1'b1);
		check(hrd, 16'h0000);
		check(lows[B_OE], 1);
		rd(`GHBI_OFF_ATTR, 32'h1, 32'h0);
	endtask
	task automatic t_io_width();
		logic [9:0] p [10] = '{10'h3c4, 10'h3ce, 10'h3b4, 10'h3c0, 10'h3c6, 10'h3c7,
			10'h3c8, 10'h3c9, 10'h3c2, 10'h3ba};
		wr(`GHBI_OFF_CTRL, 32'h2);
		for (int i = 0; i < 10; i++) begin
			hc(IWR, {10'h000, p[i]}, 16'h0000, 1'b0);
			check(lows[B_I16], i < 4);
			check(lows[B_PWR], i >= 4 && i < 8);
		end
		hc(IRD, 20'h003c7, 16'h0000, 1'b1);
		check(lows[1:0], 2'b10);
		check(lows[B_OE], 0);
		hc(IWR, 20'h003c5, 16'h0000, 1'b0);
		check(lows[B_I16], 0);
		// Colour mode moves the CRT pair to its other base
		hc(IWR, 20'h003c2, 16'h0001, 1'b1);
		hc(IWR, 20'h003d4, 16'h0000, 1'b0);
		check(lows[B_I16], 1);
		hc(MWR, 20'ha0002, 16'h0000, 1'b0);
		check(lows[B_M16], 0);
	endtask
	task automatic t_mem_orgs();
		for (int o = 0; o < 3; o++) begin
			wr(`GHBI_OFF_CTRL, 32'h1 | (o << 2));
			hc(MWR, 20'ha1000 + 20'(o * 4), 16'hc3a0 + 16'(o), 1'b0);
			check(lows[B_M16], 1);
			hc(MRD, 20'ha1000 + 20'(o * 4), 16'h0000, 1'b0);
			check(hrd, 16'hc3a0 + 16'(o));
			check(hw, WAITS);
			check(lows[B_OE], 1);
			rd(`GHBI_OFF_LATCH, 32'hffff, 32'hc3a0 + 32'(o));
			// High byte enable off: only the low lane is written
			hc(MWR, 20'ha1000 + 20'(o * 4), 16'h0011, 1'b1);
			hc(MRD, 20'ha1000 + 20'(o * 4), 16'h0000, 1'b0);
			check(hrd, 16'hc311);
			hc(IWR, 20'h003c4, 16'h0000, 1'b0);
			check(lows[B_I16], 0);
		end
	endtask
	task automatic t_rom_strap();
		hc(MRD, 20'hc0010, 16'h0000, 1'b1);
		check(lows[B_ROM], 1);
		hc(MRD, 20'hc8000, 16'h0000, 1'b1);
		check(lows[B_ROM], 0);
		do_reset(1'b1);
		rd(`GHBI_OFF_STAT, 32'h2, 32'h2);
		hc(MRD, 20'hc0010, 16'h0000, 1'b1);
		check(lows[B_ROM], 0);
		wr(`GHBI_OFF_CTRL, 32'h1);
		hc(MRD, 20'ha0000, 16'h0000, 1'b1);
		check(lows[B_CS], 1);
		check(lows[B_DS], 1);
		check(lows[B_M16], 0);
		check(hw, WAITS);
	endtask
	initial begin
		err_count = 0;
		samples_checked = 0;
		cyc = 0;
		clr = 1'b1;
		resetn = 1'b0;
		strap = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		do_reset(1'b0);
		t_reset();
		t_ext();
		t_io_width();
		t_mem_orgs();
		t_rom_strap();
		conclude();
	end
endmodule
